// [rtl/tmr_match_out.sv]
// Interval timer core with match output routing and APB registers
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module tmr_match_out (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins
	input  wire logic        ext_int_pin,
	input  wire logic        shared_port_pin_in,
	output logic             shared_port_pin_out,
	output logic             shared_port_pin_oe,
	// Interrupt
	output logic             irq
);
	import tmr_pkg::*;

	// ==========================================
	// Bus decode
	logic wr_en;
	logic hit;
	logic wr_route;
	logic wr_ctrl;
	logic wr_modulo;
	logic wr_ien;
	logic wr_iclr;
	logic wr_port;
	assign wr_en   = psel && penable && pwrite;
	// Zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	always_comb begin
		case (paddr)
			ADDR_ROUTE:  hit = 1'b1;
			ADDR_CTRL:   hit = 1'b1;
			ADDR_MODULO: hit = 1'b1;
			ADDR_COUNT:  hit = 1'b1;
			ADDR_STAT:   hit = 1'b1;
			ADDR_IEN:    hit = 1'b1;
			ADDR_ICLR:   hit = 1'b1;
			ADDR_PORT:   hit = 1'b1;
			default:     hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !hit;
	// Writes to unmapped addresses fall through every strobe below
	assign wr_route  = wr_en && (paddr == ADDR_ROUTE);
	assign wr_ctrl   = wr_en && (paddr == ADDR_CTRL);
	assign wr_modulo = wr_en && (paddr == ADDR_MODULO);
	assign wr_ien    = wr_en && (paddr == ADDR_IEN);
	assign wr_iclr   = wr_en && (paddr == ADDR_ICLR);
	assign wr_port   = wr_en && (paddr == ADDR_PORT);

	// ==========================================
	// Pin synchronisers
	logic [1:0] ext_sync_ff;
	logic [1:0] pin_sync_ff;
	logic       ext_prev_ff;
	logic       ext_fall;
	// Stages reset to the idle high level so no false edge follows reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_ff <= 2'b11;
		end else begin
			ext_sync_ff <= {ext_sync_ff[0], ext_int_pin};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync_ff <= 2'b11;
		end else begin
			pin_sync_ff <= {pin_sync_ff[0], shared_port_pin_in};
		end
	end

	// Edge detector reads only the settled second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_ff <= 1'b1;
		end else begin
			ext_prev_ff <= ext_sync_ff[1];
		end
	end
	assign ext_fall = ext_prev_ff && !ext_sync_ff[1];

	// ==========================================
	// Registers
	logic       route_sel_ff;
	logic       count_enable_bit_ff;
	logic [1:0] clk_sel_ff;
	logic [7:0] modulo_value_reg_ff;
	logic       port_data_ff;
	logic       port_dir_bit_ff;
	logic [1:0] irq_en_ff;
	logic       clr_wr;
	// Clear is a strobe, never stored, so it reads back as 0
	assign clr_wr = wr_ctrl && pwdata[BIT_CLR];

	// Only bit 0 is stored; bits 3..1 read back as 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_sel_ff <= ROUTE_RST[BIT_ROUTE_SEL];
		end else if (wr_route) begin
			route_sel_ff <= pwdata[BIT_ROUTE_SEL];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_enable_bit_ff <= CTRL_RST[BIT_EN];
		end else if (wr_ctrl) begin
			count_enable_bit_ff <= pwdata[BIT_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sel_ff <= CTRL_RST[BIT_CKHI:BIT_CKLO];
		end else if (wr_ctrl) begin
			clk_sel_ff <= pwdata[BIT_CKHI:BIT_CKLO];
		end
	end

	// Modulo is write-only; a zero value parks the counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modulo_value_reg_ff <= MODULO_RST;
		end else if (wr_modulo) begin
			modulo_value_reg_ff <= pwdata[7:0];
		end
	end

	// Port defaults to a released input with a high latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_data_ff <= 1'b1;
		end else if (wr_port) begin
			port_data_ff <= pwdata[BIT_PORT_DATA];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_dir_bit_ff <= 1'b0;
		end else if (wr_port) begin
			port_dir_bit_ff <= pwdata[BIT_PORT_DIR];
		end
	end

	// Enable mask shares the status layout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_ff <= 2'b00;
		end else if (wr_ien) begin
			irq_en_ff <= pwdata[1:0];
		end
	end

	// ==========================================
	// Prescaler: never cleared by the clear bit, so first period may be short
	logic [10:0] pre_ff;
	logic [10:0] div_max;
	logic        cnt_pulse;
	always_comb begin
		case (clk_sel_t'(clk_sel_ff))
			CK_DIV256: div_max = DIV_256;
			CK_DIV32:  div_max = DIV_32;
			CK_DIV2K:  div_max = DIV_2048;
			default:   div_max = DIV_256;
		endcase
	end

	// Wrap test uses >= so a shorter division chosen mid-period wraps at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= '0;
		end else if (pre_ff >= div_max) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= pre_ff + 11'd1;
		end
	end

	// External edges bypass the prescaler entirely
	always_comb begin
		case (clk_sel_t'(clk_sel_ff))
			CK_EXT:  cnt_pulse = ext_fall;
			default: cnt_pulse = (pre_ff >= div_max);
		endcase
	end

	// ==========================================
	// Count register, held during a read with one deferred pulse
	logic [7:0] count_value_reg_ff;
	logic       pend_ff;
	logic       read_now;
	logic       step;
	logic       match;
	// Freeze spans setup and access so the snapshot equals the held value
	assign read_now = psel && !pwrite && (paddr == ADDR_COUNT);
	assign step     = count_enable_bit_ff && !read_now && (cnt_pulse || pend_ff);
	assign match    = step && (count_value_reg_ff == modulo_value_reg_ff)
		&& (modulo_value_reg_ff != 8'h00);

	// Only one pulse is remembered; a second one in the same read is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_ff <= 1'b0;
		end else if (clr_wr) begin
			pend_ff <= 1'b0;
		end else if (read_now && count_enable_bit_ff && cnt_pulse) begin
			pend_ff <= 1'b1;
		end else if (step) begin
			pend_ff <= 1'b0;
		end
	end

	// Wrap to zero on match gives one match every N+1 pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value_reg_ff <= 8'h00;
		end else if (clr_wr) begin
			count_value_reg_ff <= 8'h00;
		end else if (match) begin
			count_value_reg_ff <= 8'h00;
		end else if (step && modulo_value_reg_ff != 8'h00) begin
			count_value_reg_ff <= count_value_reg_ff + 8'h01;
		end
	end

	// ==========================================
	// Match output flip-flop
	logic match_ff;
	// Toggles only on a counted match, so a disabled timer holds its level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_ff <= 1'b0;
		end else if (clr_wr) begin
			match_ff <= 1'b0;
		end else if (match) begin
			match_ff <= !match_ff;
		end
	end

	// ==========================================
	// Sticky status, set wins over an ICLR clear; a count clear beats a match
	logic [1:0] status_ff;
	logic [1:0] set_ev;
	logic [1:0] clr_mask;
	assign set_ev   = {ext_fall, match};
	assign clr_mask = wr_iclr ? pwdata[1:0] : 2'b00;
	// Count clear also drops the match flag; the edge flag is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= 2'b00;
		end else if (clr_wr) begin
			status_ff <= {status_ff[BIT_ST_EXT] | set_ev[BIT_ST_EXT], 1'b0};
		end else begin
			status_ff <= (status_ff & ~clr_mask) | set_ev;
		end
	end

	// Level output, high while any enabled flag stands
	assign irq = |(status_ff & irq_en_ff);

	// ==========================================
	// Shared pin: open-drain, route ignores direction bit
	logic pin_level;
	// Released level stands for the port's own high output
	always_comb begin
		if (route_sel_ff) begin
			pin_level = match_ff;
		end else if (port_dir_bit_ff) begin
			pin_level = port_data_ff;
		end else begin
			pin_level = 1'b1;
		end
	end
	assign shared_port_pin_out = 1'b0;
	assign shared_port_pin_oe  = !pin_level;

	// ==========================================
	// Read data
	// Loaded in setup so the word stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= ZERO_WORD;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
				ADDR_ROUTE: prdata <= {31'd0, route_sel_ff};
				ADDR_CTRL:  prdata <= {28'd0, clk_sel_ff, 1'b0, count_enable_bit_ff};
				ADDR_COUNT: prdata <= {24'd0, count_value_reg_ff};
				ADDR_MODULO: prdata <= ZERO_WORD;
				ADDR_ICLR:  prdata <= ZERO_WORD;
				ADDR_STAT:  prdata <= {30'd0, status_ff};
				ADDR_IEN:   prdata <= {30'd0, irq_en_ff};
				ADDR_PORT:  prdata <= {29'd0, pin_sync_ff[1], port_dir_bit_ff, port_data_ff};
				default:    prdata <= ZERO_WORD;
			endcase
		end
	end
endmodule : tmr_match_out

// [rtl/tmr_pkg.sv]
// Constants for the interval timer with match output and source-clock select
package tmr_pkg;
	// ==========================================
	// Register byte addresses
	// Route register keeps its word index; its byte address is four times it
	localparam logic [7:0] IDX_ROUTE   = 8'h12;
	localparam logic [7:0] ADDR_ROUTE  = {IDX_ROUTE[5:0], 2'b00};
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_MODULO = 8'h04;
	localparam logic [7:0] ADDR_COUNT  = 8'h08;
	localparam logic [7:0] ADDR_STAT   = 8'h0C;
	localparam logic [7:0] ADDR_IEN    = 8'h10;
	localparam logic [7:0] ADDR_ICLR   = 8'h14;
	localparam logic [7:0] ADDR_PORT   = 8'h18;
	// ==========================================
	// Field positions
	localparam int BIT_ROUTE_SEL = 0;
	localparam int BIT_EN        = 0;
	localparam int BIT_CLR       = 1;
	localparam int BIT_CKLO      = 2;
	localparam int BIT_CKHI      = 3;
	localparam int BIT_ST_MATCH  = 0;
	localparam int BIT_ST_EXT    = 1;
	localparam int BIT_PORT_DATA = 0;
	localparam int BIT_PORT_DIR  = 1;
	// ==========================================
	// Reset values and divisions
	localparam logic [3:0]  ROUTE_RST  = 4'h0;
	localparam logic [3:0]  CTRL_RST   = 4'h0;
	localparam logic [7:0]  MODULO_RST = 8'hFF;
	localparam logic [10:0] DIV_256    = 11'd255;
	localparam logic [10:0] DIV_32     = 11'd31;
	localparam logic [10:0] DIV_2048   = 11'd2047;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
	typedef enum logic [1:0] {
		CK_DIV256 = 2'b00,
		CK_DIV32  = 2'b01,
		CK_DIV2K  = 2'b10,
		CK_EXT    = 2'b11
	} clk_sel_t;
endpackage : tmr_pkg

// [tb/tmr_pin_load.sv]
// Partner model: pull-up load on the open-drain timer pin
`timescale 1ns/1ps
module tmr_pin_load (
	input  wire logic oe,
	output logic      pin
);
	// Released line reads high through the fitted pull-up
	assign pin = oe ? 1'b0 : 1'b1;
endmodule : tmr_pin_load

// [tb/tmr_match_out_assertions.sv]
// Port checker for the timer match output block
`timescale 1ns/1ps
module tmr_match_out_assertions
	import tmr_pkg::*;
(
	input wire logic        pclk, presetn, psel, penable, pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic        pready, pslverr, shared_port_pin_out, shared_port_pin_oe, irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd  = psel && penable && !pwrite;
	wire map = paddr inside {ADDR_CTRL, ADDR_MODULO, ADDR_COUNT, ADDR_STAT, ADDR_IEN,
		ADDR_ROUTE, ADDR_ICLR, ADDR_PORT};
	a_pin_low: assert property (shared_port_pin_out == 1'b0) else $error("pin data not low");
	a_rst_release: assert property ($rose(presetn) |-> !shared_port_pin_oe && !irq)
		else $error("pin or irq active after reset");
	a_ready_high: assert property (psel |-> pready) else $error("pready low");
	a_unmapped_err: assert property (psel && penable && !map
		|-> pslverr && (pwrite || prdata == ZERO_WORD))
		else $error("unmapped access not refused");
	a_route_ok: assert property (psel && penable && paddr == ADDR_ROUTE |-> !pslverr)
		else $error("route register refused");
	a_route_bits: assert property (rd && paddr == ADDR_ROUTE |-> prdata[31:1] == 31'h0)
		else $error("route spare bits not zero");
	a_modulo_wo: assert property (rd && paddr == ADDR_MODULO |-> prdata == ZERO_WORD)
		else $error("modulo readable");
	a_irq_mask: assert property (psel && penable && pwrite && paddr == ADDR_IEN
		&& pwdata == ZERO_WORD |=> !irq[*2]) else $error("masked irq high");
	c_refused: cover property (psel && penable && pslverr);
	c_pin_drive: cover property ($rose(shared_port_pin_oe));
	c_irq: cover property ($rose(irq));
endmodule : tmr_match_out_assertions
bind tmr_match_out tmr_match_out_assertions u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.shared_port_pin_out(shared_port_pin_out), .shared_port_pin_oe(shared_port_pin_oe));

// [tb/tmr_match_out_tb.sv]
// Testbench for the timer match output block
`timescale 1ns/1ps
module tmr_match_out_tb;
	import tmr_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_int_pin = 1;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, err, pin_out, pin_oe, pin, irq;
	int          errors = 0, compares = 0;
	`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
		$display("[ERR] %0t got %h exp %h", $time, g, e); end end
	always #20 pclk = ~pclk;
	tmr_match_out dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_int_pin(ext_int_pin), .shared_port_pin_in(pin),
		.shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe), .irq(irq));
	tmr_pin_load load (.oe(pin_oe), .pin(pin));
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		// Let the completing edge settle before any check
		#1;
	endtask : apb
	task automatic wait_pin(input logic v, output int n);
		n = 0;
		while (pin !== v && n < 9000) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_pin
	task automatic t_reset_regs;
		`CHK(pin, 1'b1)
		apb(0, ADDR_ROUTE, 0);
		`CHK(rd, ZERO_WORD)
		apb(1, ADDR_ROUTE, 32'h0000_000F);
		apb(0, ADDR_ROUTE, 0);
		`CHK(rd, 32'h0000_0001)
		apb(0, 8'h20, 0);
		`CHK(err, 1'b1)
	endtask : t_reset_regs
	task automatic t_periods;
		int n;
		clk_sel_t s [3] = '{CK_DIV256, CK_DIV32, CK_DIV2K};
		int p [3] = '{512, 64, 4096};
		apb(1, ADDR_MODULO, 32'h0000_0001);
		// Port released as input: only the timer can pull the pin low
		apb(1, ADDR_PORT, ZERO_WORD);
		foreach (s[i]) begin
			apb(1, ADDR_CTRL, {28'h000_0000, s[i], 2'b11});
			`CHK(pin, 1'b0)
			wait_pin(1'b1, n);
			wait_pin(1'b0, n);
			`CHK(n, p[i])
		end
	endtask : t_periods
	task automatic t_hold_irq;
		logic h;
		apb(1, ADDR_IEN, 32'h0000_0001);
		`CHK(irq, 1'b1)
		apb(1, ADDR_IEN, ZERO_WORD);
		`CHK(irq, 1'b0)
		apb(1, ADDR_CTRL, 32'h0000_0004);
		h = pin;
		repeat (300) @(posedge pclk);
		`CHK(pin, h)
		apb(1, ADDR_ICLR, 32'h0000_0001);
		apb(1, ADDR_IEN, 32'h0000_0001);
		`CHK(irq, 1'b0)
		apb(1, ADDR_CTRL, 32'h0000_0007);
		`CHK(pin, 1'b0)
		apb(0, ADDR_COUNT, 0);
		`CHK(rd <= 1, 1'b1)
		apb(0, ADDR_STAT, 0);
		`CHK(rd[0], 1'b0)
	endtask : t_hold_irq
	task automatic t_port_mode;
		apb(1, ADDR_ROUTE, ZERO_WORD);
		`CHK(pin, 1'b1)
		apb(1, ADDR_PORT, 32'h0000_0002);
		`CHK(pin, 1'b0)
	endtask : t_port_mode
	task automatic t_ext_count;
		apb(1, ADDR_MODULO, 32'h0000_00FF);
		apb(1, ADDR_CTRL, 32'h0000_000F);
		repeat (3) begin
			ext_int_pin <= 0;
			repeat (6) @(posedge pclk);
			ext_int_pin <= 1;
			repeat (6) @(posedge pclk);
		end
		apb(0, ADDR_COUNT, 0);
		`CHK(rd, 32'h0000_0003)
	endtask : t_ext_count
	task automatic end_of_test;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		t_reset_regs();
		t_periods();
		t_hold_irq();
		t_port_mode();
		t_ext_count();
		end_of_test();
	end
endmodule : tmr_match_out_tb
